// File: src/scr_pkg.sv
package scr_pkg;

  // Result width of the default resolution variant; 14 and 12 are the other builds.
  localparam int RES_BITS_DEFAULT = 16;

  // Internal conversion clock period.
  localparam int MCLK_PERIOD_NS = 50;

  // Conversion duration, timed only by the internal clock.
  localparam int CONV_TIME_NS = 900;
  localparam int CONV_CYCLES = (CONV_TIME_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

  // Power-up self-calibration duration.
  localparam int CAL_TIME_US = 250;
  localparam int CAL_CYCLES = (CAL_TIME_US * 1000) / MCLK_PERIOD_NS;

  // Synchroniser reset level of the start/select pin. It matches the idle-high pin, so the
  // release of reset cannot show a false rising edge to the start detector.
  localparam logic CS_SYNC_RESET = 1'b1;

  // Phase indicators handed to the analog core.
  typedef struct packed {
    logic calibrating;   // Self-calibration in progress.
    logic sampling;      // Sampling switches closed, low-current acquisition.
    logic converting;    // Successive approximation running.
  } scr_status_t;

  typedef enum logic [1:0] {
    CALIBRATE,
    ACQUIRE,
    CONVERT
  } scr_state_t;

endpackage

// File: src/scr_serial_readout.sv
`timescale 1ns/1ns
// Serial shifter on the host's serial clock. The held result word does not change while the
// start/select line is low, because a new result only lands at the end of a conversion, and
// the host keeps the line high for that whole time; this makes the word safe to read here.
module scr_serial_readout #(
  parameter int W = scr_pkg::RES_BITS_DEFAULT
) (
  input  wire logic         sclk,    // Host serial clock.
  input  wire logic         csPin,   // Start/select pin, high clears the bit position.
  input  wire logic [W-1:0] word,    // Held result word.
  output logic              sdo      // Serial data output.
);

  localparam int IW = $clog2(W + 1);
  localparam logic [IW-1:0] LAST_IDX = IW'(W);

  logic [IW-1:0] bitIdx;

  // The bit position advances on the falling edge so that the host samples on the rising one.
  always_ff @(negedge sclk or posedge csPin) begin
    if (csPin) begin
      bitIdx <= '0;
    end else if (bitIdx < LAST_IDX) begin
      bitIdx <= bitIdx + 1'b1;
    end
  end

  // The most significant bit is shown as soon as the line falls, before any clock edge.
  always_comb begin
    if (bitIdx < LAST_IDX) begin
      sdo = word[W - 1 - int'(bitIdx)];
    end else begin
      sdo = 1'b0;
    end
  end

  chk_msb_first: assert property (@(posedge sclk) disable iff (csPin)
    (bitIdx == '0) |-> (sdo == word[W-1]))
    else $error("first bit shown is not the most significant bit");

  chk_one_bit_step: assert property (@(posedge sclk) disable iff (csPin)
    (bitIdx > '0 && $past(bitIdx) < LAST_IDX && $stable(word)) |-> (bitIdx == $past(bitIdx) + 1'b1))
    else $error("bit position did not advance by one per clock");

endmodule

// File: src/scr_sar_readout_top.sv
`timescale 1ns/1ns
// Contract
// - Self-calibrate at power-up, then enter standby acquisition.
// - Start/select rising edge begins a conversion.
// - Conversion length set by internal clock only.
// - Host lowers line after conversion; result then shown.
// - After conversion, return to sampling automatically.
// - Three-wire serial interface: select, clock, data.
// - Overrange input gives saturated code, sign kept.
// - Signed code spans minus to plus reference minus one.
// - Result shifted out MSB first, one per clock.
// - One pin starts conversion and selects readout.
module scr_sar_readout_top #(
  parameter int W          = scr_pkg::RES_BITS_DEFAULT,
  parameter int CAL_CYCLES = scr_pkg::CAL_CYCLES
) (
  input  wire logic              mclk,                     // Internal conversion clock, 20 MHz.
  input  wire logic              rst_n,                    // Power-up reset, asynchronous, active low.
  input  wire logic              convert_start_select_n,   // Start/select pin from the host.
  input  wire logic              sclk,                     // Host serial clock, readout only.
  input  wire logic signed [W+1:0] analogLevel,            // Differential input in steps, one step per code.
  output wire logic              sdo,                      // Serial data output.
  output scr_pkg::scr_status_t   status                    // Phase indicators for the analog core.
);

  localparam int CONV_CYCLES = scr_pkg::CONV_CYCLES;
  localparam int CCW = $clog2(CONV_CYCLES + 1);
  localparam int KCW = $clog2(CAL_CYCLES + 1);
  localparam logic [CCW-1:0] CONV_LAST = CCW'(CONV_CYCLES - 1);
  localparam logic [CCW-1:0] SAR_STEPS = CCW'(W);
  localparam logic [KCW-1:0] CAL_LAST = KCW'(CAL_CYCLES - 1);

  // Code limits: plus reference saturates one step below, minus reference is reachable.
  localparam logic [W-1:0] MAX_CODE = {1'b0, {(W-1){1'b1}}};
  localparam logic [W-1:0] MIN_CODE = {1'b1, {(W-1){1'b0}}};
  localparam logic [W-1:0] MSB_MASK = {1'b1, {(W-1){1'b0}}};
  localparam logic signed [W+1:0] MAX_LEVEL = $signed({3'b000, {(W-1){1'b1}}});
  localparam logic signed [W+1:0] MIN_LEVEL = $signed({3'b111, {(W-1){1'b0}}});

  // Clamp the input to the signed code span; overrange keeps only the sign.
  function automatic logic [W-1:0] clampToSpan(input logic signed [W+1:0] level);
    logic [W-1:0] code;
    code = level[W-1:0];
    if (level > MAX_LEVEL) begin
      code = MAX_CODE;
    end else if (level < MIN_LEVEL) begin
      code = MIN_CODE;
    end
    return code;
  endfunction

  scr_pkg::scr_state_t state;
  scr_pkg::scr_state_t next_state;

  logic             csMeta;
  logic             csSync;
  logic             csPrev;
  logic             csRise;
  logic [KCW-1:0]   calCount;
  logic [CCW-1:0]   convCount;
  logic [W-1:0]     sampleHeld;
  logic [W-1:0]     approx;
  logic [W-1:0]     trial;
  logic [W-1:0]     target;
  logic [W-1:0]     result;
  logic signed [W+1:0] rawHeld;
  logic [CCW:0]     convSpan;

  // The pin is asynchronous to the internal clock; the first flop is never read, only the second and third.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      csMeta <= scr_pkg::CS_SYNC_RESET;
      csSync <= scr_pkg::CS_SYNC_RESET;
      csPrev <= scr_pkg::CS_SYNC_RESET;
    end else begin
      csMeta <= convert_start_select_n;
      csSync <= csMeta;
      csPrev <= csSync;
    end
  end

  assign csRise = csSync & ~csPrev;

  // A rising edge during calibration or conversion is ignored rather than queued, so a
  // host that toggles early simply loses that start instead of corrupting a running one.
  always_comb begin
    next_state = state;
    case (state)
      scr_pkg::CALIBRATE: begin
        if (calCount == CAL_LAST) begin
          next_state = scr_pkg::ACQUIRE;
        end
      end
      scr_pkg::ACQUIRE: begin
        if (csRise) begin
          next_state = scr_pkg::CONVERT;
        end
      end
      scr_pkg::CONVERT: begin
        if (convCount == CONV_LAST) begin
          next_state = scr_pkg::ACQUIRE;
        end
      end
      default: begin
        next_state = scr_pkg::CALIBRATE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= scr_pkg::CALIBRATE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      status <= '{calibrating: 1'b1, sampling: 1'b0, converting: 1'b0};
    end else begin
      status.calibrating <= (next_state == scr_pkg::CALIBRATE);
      status.sampling    <= (next_state == scr_pkg::ACQUIRE);
      status.converting  <= (next_state == scr_pkg::CONVERT);
    end
  end

  // Calibration runs once after reset with no command from the host.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      calCount <= '0;
    end else if (state == scr_pkg::CALIBRATE && calCount != CAL_LAST) begin
      calCount <= calCount + 1'b1;
    end
  end

  // The conversion length counts internal clocks only; the serial clock never reaches here.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      convCount <= '0;
    end else if (state == scr_pkg::CONVERT && convCount != CONV_LAST) begin
      convCount <= convCount + 1'b1;
    end else begin
      convCount <= '0;
    end
  end

  // The input is held at the end of acquisition, clamped into the code span.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sampleHeld <= '0;
      rawHeld    <= '0;
    end else if (state == scr_pkg::ACQUIRE && csRise) begin
      sampleHeld <= clampToSpan(analogLevel);
      rawHeld    <= analogLevel;
    end
  end

  // The search works in offset binary, which orders codes as unsigned numbers.
  assign target = sampleHeld ^ MSB_MASK;
  assign trial  = approx | (MSB_MASK >> convCount);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      approx <= '0;
    end else if (state != scr_pkg::CONVERT) begin
      approx <= '0;
    end else if (convCount < SAR_STEPS && trial <= target) begin
      approx <= trial;
    end
  end

  // The result only changes at the end of a conversion, while the line is high, which keeps
  // it steady for the whole readout in the serial clock domain.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      result <= '0;
    end else if (state == scr_pkg::CONVERT && convCount == CONV_LAST) begin
      result <= approx ^ MSB_MASK;
    end
  end

  scr_serial_readout #(
    .W (W)
  ) u_readout (
    .sclk  (sclk),
    .csPin (convert_start_select_n),
    .word  (result),
    .sdo   (sdo)
  );

  // Helper: length of the current conversion in internal clocks.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      convSpan <= '0;
    end else if (status.converting) begin
      convSpan <= convSpan + 1'b1;
    end else begin
      convSpan <= '0;
    end
  end

  chk_cal_to_standby: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == scr_pkg::CALIBRATE && calCount == CAL_LAST) |=> (state == scr_pkg::ACQUIRE) ##1 status.sampling)
    else $error("calibration did not end in standby acquisition");

  chk_cal_ignores_pin: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == scr_pkg::CALIBRATE && calCount != CAL_LAST) |=> (state == scr_pkg::CALIBRATE))
    else $error("calibration left early");

  chk_edge_starts: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == scr_pkg::ACQUIRE && csRise) |=> (state == scr_pkg::CONVERT) ##1 status.converting)
    else $error("rising edge did not start a conversion");

  chk_conv_length: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(status.converting) |-> (convSpan == (CCW+1)'(CONV_CYCLES)))
    else $error("conversion length differs from the internal count");

  chk_back_to_sampling: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == scr_pkg::CONVERT && convCount == CONV_LAST) |=> (state == scr_pkg::ACQUIRE) ##1 status.sampling)
    else $error("device did not return to acquisition after conversion");

  chk_sat_high: assert property (@(posedge mclk) disable iff (!rst_n)
    ($fell(status.converting) && rawHeld > MAX_LEVEL) |-> (result == MAX_CODE))
    else $error("positive overrange did not saturate");

  chk_sat_low: assert property (@(posedge mclk) disable iff (!rst_n)
    ($fell(status.converting) && rawHeld < MIN_LEVEL) |-> (result == MIN_CODE))
    else $error("negative overrange did not saturate");

  chk_code_span: assert property (@(posedge mclk) disable iff (!rst_n)
    ($fell(status.converting) && rawHeld <= MAX_LEVEL && rawHeld >= MIN_LEVEL) |-> (result == rawHeld[W-1:0]))
    else $error("in-range input gave the wrong code");

  chk_result_steady: assert property (@(posedge mclk) disable iff (!rst_n)
    (state != scr_pkg::CONVERT) |=> $stable(result))
    else $error("result changed outside a conversion");

  // These watch internal registers that the pins alone cannot reveal, except the first, which checks the status output.
  chk_status_onehot: assert property (@(posedge mclk) disable iff (!rst_n)
    $onehot(status))
    else $error("phase indicators are not one-hot");

  chk_cal_once: assert property (@(posedge mclk) disable iff (!rst_n)
    (state != scr_pkg::CALIBRATE) |=> (state != scr_pkg::CALIBRATE))
    else $error("calibration ran again without a reset");

  chk_cal_count_step: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == scr_pkg::CALIBRATE && calCount != CAL_LAST) |=> (calCount == $past(calCount) + 1'b1))
    else $error("calibration count did not advance by one");

  chk_cal_no_sample: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == scr_pkg::CALIBRATE) |=> $stable(rawHeld))
    else $error("input was sampled during calibration");

  chk_acquire_waits: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == scr_pkg::ACQUIRE && !csRise) |=> (state == scr_pkg::ACQUIRE))
    else $error("acquisition left without a rising edge");

  chk_sample_on_edge: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == scr_pkg::ACQUIRE && csRise) |=> (rawHeld == $past(analogLevel)))
    else $error("input was not held at the start edge");

  chk_busy_no_sample: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == scr_pkg::CONVERT) |=> $stable(rawHeld))
    else $error("input was sampled again during a conversion");

  chk_start_while_busy: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == scr_pkg::CONVERT && convCount != CONV_LAST) |=> (state == scr_pkg::CONVERT))
    else $error("conversion ended before its internal count");

  chk_conv_from_zero: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(status.converting) |-> (convCount == '0 && approx == '0))
    else $error("conversion did not start from a cleared search");

  chk_count_step: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == scr_pkg::CONVERT && convCount != CONV_LAST) |=> (convCount == $past(convCount) + 1'b1))
    else $error("conversion count did not advance by one");

  chk_approx_grows: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == scr_pkg::CONVERT && $past(state) == scr_pkg::CONVERT) |-> ((approx & $past(approx)) == $past(approx)))
    else $error("search cleared a bit it had kept");

  chk_below_target: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == scr_pkg::CONVERT) |-> (approx <= target))
    else $error("search passed the held input");

  chk_search_done: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == scr_pkg::CONVERT && convCount == SAR_STEPS) |-> (approx == target))
    else $error("search did not settle on the held input");

  chk_search_bound: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == scr_pkg::CONVERT && convCount >= SAR_STEPS) |=> $stable(approx))
    else $error("search tried more bits than the word width");

  chk_sign_kept: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(status.converting) |-> (result[W-1] == rawHeld[W+1]))
    else $error("result sign differs from the input sign");

endmodule

// File: sim/scr_host_model.sv
`timescale 1ns/1ns
// Host side of the three-wire readout. The serial clock rests low outside a read frame, so
// the device never sees shifting while it converts.
module scr_host_model #(
  parameter int W       = scr_pkg::RES_BITS_DEFAULT,
  parameter int WAIT_NS = 1200,
  parameter int HALF_NS = 32
) (
  output logic      csN,   // Start/select line, idles high.
  output logic      sclk,  // Serial clock, 64 ns period inside frames.
  input  wire logic sdo    // Serial data from the device.
);
  initial begin
    csN = 1'b1;
    sclk = 1'b0;
  end

  task automatic pulse_start();
    csN = 1'b0;
    #100;
    csN = 1'b1;
  endtask

  task automatic convert_and_read(output logic [W-1:0] word, output logic tail);
    pulse_start();
    // The wait covers the longest conversion plus the device's input synchroniser.
    #(WAIT_NS);
    csN = 1'b0;
    for (int i = W - 1; i >= 0; i--) begin
      #(HALF_NS);
      sclk = 1'b1;
      word[i] = sdo;
      #(HALF_NS);
      sclk = 1'b0;
    end
    #(HALF_NS);
    tail = sdo;
    csN = 1'b1;
  endtask
endmodule

// File: sim/tb_top.sv
`timescale 1ns/1ns
`define CHECK(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin mismatches++; \
  $display("MISMATCH %s expected %0h seen %0h", what, exp, got); end end
module tb_top;
  localparam int W       = 12;
  localparam int CAL     = 20;
  localparam int TIMEOUT = 3000;

  logic                mclk;
  logic                rst_n;
  logic                csN;
  logic                sclk;
  logic                sdo;
  logic signed [W+1:0] analogLevel;
  scr_pkg::scr_status_t status;
  int                  mismatches = 0;
  int                  n_compared = 0;
  int                  cycles = 0;

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  scr_sar_readout_top #(.W(W), .CAL_CYCLES(CAL)) dut (
    .mclk(mclk), .rst_n(rst_n), .convert_start_select_n(csN), .sclk(sclk),
    .analogLevel(analogLevel), .sdo(sdo), .status(status));

  scr_host_model #(.W(W)) host (.csN(csN), .sclk(sclk), .sdo(sdo));

  task automatic finish_test();
    if (mismatches == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == TIMEOUT) begin
      mismatches++;
      finish_test();
    end
  end

  // A start pulse during calibration must leave no trace once calibration is over.
  task automatic t_calibration();
    repeat (2) @(posedge mclk);
    #2;
    `CHECK("status in reset", 3'h4, status)
    rst_n = 1'b1;
    host.pulse_start();
    repeat (6) @(posedge mclk);
    #2;
    `CHECK("status calibrating", 3'h4, status)
    repeat (CAL) @(posedge mclk);
    #2;
    `CHECK("status standby", 3'h2, status)
  endtask

  task automatic run_conversion(input int level);
    logic [W-1:0] word;
    logic [W-1:0] expected;
    logic         tail;
    int           clamped;
    int           convCycles;
    int           tailConv;
    clamped = level;
    if (clamped > (1 << (W - 1)) - 1) clamped = (1 << (W - 1)) - 1;
    if (clamped < -(1 << (W - 1))) clamped = -(1 << (W - 1));
    expected = clamped[W-1:0];
    convCycles = 0;
    tailConv = 0;
    @(posedge mclk);
    #2;
    analogLevel = level[W+1:0];
    fork
      host.convert_and_read(word, tail);
      // The window closes before the host raises the line after the read, because that
      // rising edge starts a further conversion.
      repeat (40) begin
        @(posedge mclk);
        #2;
        if (status.converting === 1'b1) convCycles++;
      end
    join
    `CHECK("result word", expected, word)
    `CHECK("data after last bit", 1'b0, tail)
    `CHECK("conversion cycles", scr_pkg::CONV_CYCLES, convCycles)
    `CHECK("status after read", 3'h2, status)
    // The closing rising edge of the read starts a conversion; let it run to its end.
    repeat (25) begin
      @(posedge mclk);
      #2;
      if (status.converting === 1'b1) tailConv++;
    end
    `CHECK("conversion from closing edge", scr_pkg::CONV_CYCLES, tailConv)
  endtask

  // Boundaries of the signed span and inputs beyond the reference on both sides.
  task automatic t_codes();
    int levels[10] = '{0, 1, -1, 1365, 2047, -2048, 2048, -2049, 4000, -5000};
    foreach (levels[i]) run_conversion(levels[i]);
  endtask

  initial begin
    rst_n = 1'b0;
    analogLevel = '0;
    t_calibration();
    t_codes();
    finish_test();
  end
endmodule
